//--- logic/atpb_pkg.sv
/*
  Package for the arbitration table and power budget register block.
  Holds offsets, field positions, reset values and the carrier structs.
  Assumes a 32-bit APB register bus.
*/
`default_nettype none
package atpb_pkg;
  localparam logic [11:0] ATPB_OFS_TBL1      = 12'h244;
  localparam logic [11:0] ATPB_OFS_TBL2      = 12'h248;
  localparam logic [11:0] ATPB_OFS_TBL3      = 12'h24C;
  localparam logic [11:0] ATPB_OFS_PB_HDR    = 12'h280;
  localparam logic [11:0] ATPB_OFS_PB_SEL    = 12'h284;
  localparam logic [11:0] ATPB_OFS_PB_DATA   = 12'h288;
  localparam logic [11:0] ATPB_OFS_PB_VAL0   = 12'h300;
  localparam logic [11:0] ATPB_OFS_PB_VAL7   = 12'h31C;
  localparam logic [11:0] ATPB_OFS_TBL_CTL   = 12'h290;
  localparam int          ATPB_SLOT_W        = 4;
  localparam int          ATPB_SLOTS_WORD    = 8;
  localparam int          ATPB_CAPABILITY_IDENTIFIER_LSB     = 0;
  localparam int          ATPB_CAPABILITY_VERSION_LSB    = 16;
  localparam int          ATPB_NEXT_STRUCTURE_POINTER_LSB    = 20;
  localparam int          ATPB_SEL_W         = 8;
  localparam int          ATPB_CTL_LOAD_BIT  = 0;
  localparam int          ATPB_CTL_FLAG_BIT  = 16;
  localparam logic [7:0]  ATPB_SEL_MAX       = 8'h07;
  localparam logic [3:0]  ATPB_PORT_MAX      = 4'h7;
  localparam logic [31:0] ATPB_WORD_RST      = 32'h0000_0000;
  localparam logic [15:0] ATPB_CAPABILITY_IDENTIFIER_RST     = 16'h0000;
  localparam logic [3:0]  ATPB_CAPABILITY_VERSION_RST    = 4'h0;
  localparam logic [11:0] ATPB_NEXT_STRUCTURE_POINTER_RST    = 12'h000;
  localparam logic [7:0]  ATPB_SEL_RST       = 8'h00;
  localparam int          ATPB_LOAD_CYCLES   = 24;

  typedef struct packed {
    logic [11:0] next_structure_pointer;
    logic [3:0]  capability_version;
    logic [15:0] capability_identifier;
  } atpb_hdr_t;

  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } atpb_req_t;
endpackage : atpb_pkg
`default_nettype wire

//--- logic/atpb_value_mem.sv
/*
  Eight-word store for the power data values, read data registered.
  Assumes writes are already qualified by the unlock condition.
*/
`timescale 1ns/100ps
`default_nettype none
module atpb_value_mem #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  logic [31:0] mem_q [DEPTH];

  // Contents are undefined after power-up, so the array has no reset.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule : atpb_value_mem
`default_nettype wire

//--- logic/atpb_regs.sv
/*
  Port arbitration table words 1 to 3 and the power budget header,
  data select, data readout and value store, reached over APB.
  Assumes pclk at 50 MHz, presetn asynchronous active low, and that the
  unlock inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module atpb_regs
  import atpb_pkg::*;
#(
  parameter int LOAD_CYCLES = ATPB_LOAD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        header_unlock,
  input  wire logic        value_unlock,
  input  wire logic [2:0]  egress_port,
  input  wire logic        arb_advance,
  output logic      [3:0]  arb_port,
  output logic             arb_port_valid,
  output logic             table_coherency_flag
);
  typedef enum logic [2:0] {
    ATPB_IDLE   = 3'b001,
    ATPB_ACCESS = 3'b010,
    ATPB_DONE   = 3'b100
  } atpb_bus_t;

  atpb_bus_t   bus_q, bus_d;
  logic [31:0] tbl_q [3];
  logic [31:0] tbl_d [3];
  atpb_hdr_t   hdr_q, hdr_d;
  logic [7:0]  sel_q, sel_d;
  logic        flag_q, flag_d;
  logic        loading_q, loading_d;
  logic [7:0]  load_cnt_q, load_cnt_d;
  logic [31:0] prdata_d;
  logic        pslverr_d;
  logic [4:0]  phase_q, phase_d;
  logic [3:0]  port_q, port_d;
  logic        port_vld_q, port_vld_d;
  logic [31:0] tbl_view [3];
  logic [31:0] mem_rdata;
  logic        mem_we;
  logic        setup;
  logic        wr_acc;
  logic [3:0]  slot_code;
  logic [2:0]  word_idx;

  assign setup  = psel && !penable;
  assign wr_acc = (bus_q == ATPB_ACCESS) && pwrite;
  assign mem_we = wr_acc && value_unlock && (paddr >= ATPB_OFS_PB_VAL0)
                  && (paddr <= ATPB_OFS_PB_VAL7) && (paddr[1:0] == 2'b00);

  // The store is read continuously at the current selector; the readout word
  // therefore lags a selector write by one cycle, well before any new access.
  atpb_value_mem #(
    .DEPTH (8),
    .AW    (3)
  ) u_value_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (paddr[4:2]),
    .wdata (pwdata),
    .raddr (sel_q[2:0]),
    .rdata (mem_rdata)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Slot views of the table words, each slot four bits wide.
  always_comb begin
    for (int w = 0; w < 3; w++) begin
      tbl_view[w] = tbl_q[w];
    end
  end

  // APB: one wait state, so each access answers two cycles after setup.
  always_comb begin
    bus_d     = bus_q;
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    case (bus_q)
      ATPB_IDLE: begin
        if (setup) begin
          bus_d = ATPB_ACCESS;
        end
      end
      ATPB_ACCESS: begin
        bus_d    = ATPB_DONE;
        prdata_d = 32'h0000_0000;
        case (paddr)
          ATPB_OFS_TBL1:    prdata_d = tbl_view[0];
          ATPB_OFS_TBL2:    prdata_d = tbl_view[1];
          ATPB_OFS_TBL3:    prdata_d = tbl_view[2];
          ATPB_OFS_PB_HDR:  prdata_d = hdr_q;
          ATPB_OFS_PB_SEL:  prdata_d = {24'h000000, sel_q};
          ATPB_OFS_PB_DATA: prdata_d = (sel_q > ATPB_SEL_MAX) ? 32'h0000_0000
                                                              : mem_rdata;
          ATPB_OFS_TBL_CTL: prdata_d = {15'h0000, flag_q, 15'h0000, loading_q};
          default: begin
            if ((paddr >= ATPB_OFS_PB_VAL0) && (paddr <= ATPB_OFS_PB_VAL7)
                && (paddr[1:0] == 2'b00)) begin
              prdata_d = 32'h0000_0000;
            end else begin
              pslverr_d = 1'b1;
            end
          end
        endcase
        if (pwrite) begin
          prdata_d = 32'h0000_0000;
        end
      end
      ATPB_DONE: begin
        bus_d = setup ? ATPB_ACCESS : ATPB_IDLE;
      end
      default: bus_d = ATPB_IDLE;
    endcase
  end

  // Register writes, the coherency flag and the table load sequence.
  always_comb begin
    for (int w = 0; w < 3; w++) begin
      tbl_d[w] = tbl_q[w];
    end
    hdr_d      = hdr_q;
    sel_d      = sel_q;
    flag_d     = flag_q;
    loading_d  = loading_q;
    load_cnt_d = load_cnt_q;
    word_idx   = 3'b000;
    if (loading_q) begin
      if (load_cnt_q == 8'(LOAD_CYCLES - 1)) begin
        loading_d  = 1'b0;
        load_cnt_d = 8'h00;
        flag_d     = 1'b0;
      end else begin
        load_cnt_d = load_cnt_q + 8'h01;
      end
    end
    if (wr_acc) begin
      case (paddr)
        ATPB_OFS_TBL1, ATPB_OFS_TBL2, ATPB_OFS_TBL3: begin
          word_idx = 3'(paddr[3:2] - 2'b01);
          tbl_d[word_idx[1:0]] = merge(tbl_q[word_idx[1:0]], pwdata, pstrb);
          flag_d = 1'b1;
        end
        ATPB_OFS_PB_HDR: begin
          if (header_unlock) begin
            hdr_d = merge(hdr_q, pwdata, pstrb);
          end
        end
        ATPB_OFS_PB_SEL: begin
          if (pstrb[0]) begin
            sel_d = pwdata[ATPB_SEL_W-1:0];
          end
        end
        ATPB_OFS_TBL_CTL: begin
          if (pstrb[0] && pwdata[ATPB_CTL_LOAD_BIT] && !loading_q) begin
            loading_d  = 1'b1;
            load_cnt_d = 8'h00;
          end
        end
        default: ;
      endcase
    end
    // A table write landing as the load finishes keeps the flag set.
    if (wr_acc && (paddr >= ATPB_OFS_TBL1) && (paddr <= ATPB_OFS_TBL3)) begin
      flag_d = 1'b1;
    end
  end

  // Phase walker: presents slots eight to thirty-one in turn to the arbiter.
  always_comb begin
    phase_d    = phase_q;
    port_d     = port_q;
    port_vld_d = 1'b0;
    slot_code  = tbl_q[phase_q[4:3] - 2'b01][ATPB_SLOT_W*phase_q[2:0] +: ATPB_SLOT_W];
    if (arb_advance) begin
      phase_d = (phase_q == 5'd31) ? 5'd8 : phase_q + 5'd1;
      // Invalid codes drop out here, so the arbiter moves on at once.
      if (slot_code <= ATPB_PORT_MAX && slot_code[2:0] != egress_port) begin
        port_d     = slot_code;
        port_vld_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q      <= ATPB_IDLE;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      for (int w = 0; w < 3; w++) begin
        tbl_q[w] <= ATPB_WORD_RST;
      end
      hdr_q      <= {ATPB_NEXT_STRUCTURE_POINTER_RST, ATPB_CAPABILITY_VERSION_RST, ATPB_CAPABILITY_IDENTIFIER_RST};
      sel_q      <= ATPB_SEL_RST;
      flag_q     <= 1'b0;
      loading_q  <= 1'b0;
      load_cnt_q <= 8'h00;
      phase_q    <= 5'd8;
      port_q     <= 4'h0;
      port_vld_q <= 1'b0;
      arb_port       <= 4'h0;
      arb_port_valid <= 1'b0;
      table_coherency_flag <= 1'b0;
    end else begin
      bus_q      <= bus_d;
      prdata     <= prdata_d;
      pready     <= (bus_q == ATPB_ACCESS);
      pslverr    <= pslverr_d;
      for (int w = 0; w < 3; w++) begin
        tbl_q[w] <= tbl_d[w];
      end
      hdr_q      <= hdr_d;
      sel_q      <= sel_d;
      flag_q     <= flag_d;
      loading_q  <= loading_d;
      load_cnt_q <= load_cnt_d;
      phase_q    <= phase_d;
      port_q     <= port_d;
      port_vld_q <= port_vld_d;
      arb_port       <= port_d;
      arb_port_valid <= port_vld_d;
      table_coherency_flag <= flag_d;
    end
  end
endmodule : atpb_regs
`default_nettype wire

//--- testbench/atpb_regs_props.sv
/* Port checker for the arbitration table and power budget registers.
   Bound to atpb_regs from the testbench top; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module atpb_regs_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        header_unlock,
  input wire logic        value_unlock,
  input wire logic [2:0]  egress_port,
  input wire logic        arb_advance,
  input wire logic [3:0]  arb_port,
  input wire logic        arb_port_valid,
  input wire logic        table_coherency_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       done_w;
  logic       rd_w;
  logic [7:0] sel_q;
  logic [31:0] hdr_q;
  assign done_w = psel & penable & pready;
  assign rd_w   = done_w & !pwrite;
  // Shadow copies let the reads be judged against what was really written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 8'h00;
      hdr_q <= 32'h0000_0000;
    end else if (done_w && pwrite) begin
      if (paddr == 12'h284) sel_q <= pwdata[7:0];
      if (paddr == 12'h280 && header_unlock) hdr_q <= pwdata;
    end
  end
  a_table_no_err: assert property (done_w && paddr inside {12'h244, 12'h248, 12'h24C}
    |-> !pslverr)
    else $error("table word access flagged an error");
  a_hdr_no_err: assert property (done_w && paddr inside {12'h280, 12'h284}
    |-> !pslverr)
    else $error("header or select access flagged an error");
  a_sel_readback: assert property (rd_w && paddr == 12'h284 |-> prdata == {24'h0, sel_q})
    else $error("select read differs from written byte");
  a_hdr_lock: assert property (rd_w && paddr == 12'h280 |-> prdata == hdr_q)
    else $error("header read differs from unlocked writes");
  a_high_sel_zero: assert property (rd_w && paddr == 12'h288 && sel_q > 8'h07
    |-> prdata == 32'h0)
    else $error("readout not zero for high selector");
  a_flag_sets: assert property (done_w && pwrite && paddr inside {12'h244, 12'h248, 12'h24C}
    |-> ##[1:2] table_coherency_flag)
    else $error("table write did not raise coherency flag");
  a_arb_port_ok: assert property (arb_port_valid
    |-> arb_port <= 4'h7 && arb_port != {1'b0, egress_port})
    else $error("arbiter served reserved or egress port");
  a_arb_cause: assert property (arb_port_valid |-> $past(arb_advance))
    else $error("arbiter grant without advance");
  c_hdr_locked: cover property (done_w && pwrite && paddr == 12'h280 && !header_unlock);
  c_high_sel: cover property (rd_w && paddr == 12'h288 && sel_q > 8'h07);
  c_arb_grant: cover property (arb_port_valid);
endmodule : atpb_regs_props
`default_nettype wire

//--- testbench/atpb_regs_tb.sv
/* Self-checking bench for atpb_regs: APB master, read scoreboard.
   Assumes the package constants and the checker file are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module atpb_regs_tb
  import atpb_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        header_unlock = 0, value_unlock = 0, arb_advance = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, t;
  logic [3:0]  pstrb = 4'hF, arb_port;
  logic [2:0]  egress_port = 3'h5;
  logic        pready, pslverr, arb_port_valid, table_coherency_flag;
  int          fails = 0, total_checks = 0, seed = 32'h8ddfb9e3;
  logic [32:0] exp_q[$];
  logic [31:0] v[8], tw[3];
  logic [11:0] ofs[5] = '{ATPB_OFS_TBL1, ATPB_OFS_TBL2, ATPB_OFS_TBL3,
                          ATPB_OFS_PB_HDR, ATPB_OFS_PB_SEL};
  always #10 pclk = ~pclk;
  atpb_regs #(.LOAD_CYCLES(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .header_unlock(header_unlock),
    .value_unlock(value_unlock), .egress_port(egress_port), .arb_advance(arb_advance),
    .arb_port(arb_port), .arb_port_valid(arb_port_valid),
    .table_coherency_flag(table_coherency_flag));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      summarize();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next setup from reassigning psel in this step.
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Results are judged at the sampling edge, where the master takes read data.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1_FFFF_FFFF);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    int n;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ofs[i]) rd(ofs[i], 33'h0);
    check({32'h0, table_coherency_flag}, 33'h0);
    $display("test reset_values done");
    for (int i = 0; i < 3; i++) begin
      t = $random(seed) & 32'h7777_7777;
      tw[i] = t;
      apb(1'b1, ofs[i], t);
      rd(ofs[i], {1'b0, t});
    end
    pstrb <= 4'h2;
    apb(1'b1, ofs[0], 32'h0000_3300);
    pstrb <= 4'hF;
    tw[0][15:8] = 8'h33;
    rd(ofs[0], {1'b0, tw[0]});
    check({32'h0, table_coherency_flag}, 33'h1);
    apb(1'b1, ATPB_OFS_TBL_CTL, 32'h1);
    for (n = 0; n < 100 && table_coherency_flag !== 1'b0; n++) @(posedge pclk);
    check({32'h0, table_coherency_flag}, 33'h0);
    egress_port <= 3'($random(seed));
    for (int k = 0; k < 8; k++) begin
      arb_advance <= 1'b1;
      @(posedge pclk);
      arb_advance <= 1'b0;
      @(posedge pclk);
      t[3:0] = tw[0][4*k +: 4];
      t[4]   = (t[3:0] <= 4'h7) && (t[2:0] != egress_port);
      if (!t[4]) t[3:0] = 4'h0;
      t[9:5] = {arb_port_valid, arb_port_valid ? arb_port : 4'h0};
      check({28'h0, t[9:5]}, {28'h0, t[4:0]});
    end
    $display("test table_load done");
    t = $random(seed);
    apb(1'b1, ATPB_OFS_PB_HDR, t);
    rd(ATPB_OFS_PB_HDR, 33'h0);
    header_unlock <= 1'b1;
    apb(1'b1, ATPB_OFS_PB_HDR, t);
    header_unlock <= 1'b0;
    rd(ATPB_OFS_PB_HDR, {1'b0, t});
    $display("test header done");
    value_unlock <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v[i] = $random(seed);
      apb(1'b1, ATPB_OFS_PB_VAL0 + 12'(4 * i), v[i]);
    end
    value_unlock <= 1'b0;
    apb(1'b1, ATPB_OFS_PB_VAL0, ~v[0]);
    for (int i = 0; i < 11; i++) begin
      t = $random(seed);
      t[7:0] = (i < 8) ? 8'(i) : (i == 8) ? 8'h08 : {1'b1, t[6:0]};
      apb(1'b1, ATPB_OFS_PB_SEL, t);
      rd(ATPB_OFS_PB_SEL, {25'h0, t[7:0]});
      rd(ATPB_OFS_PB_DATA, (i < 8) ? {1'b0, v[i]} : 33'h0);
    end
    rd(12'h400, 33'h1_0000_0000);
    $display("test power_data done");
    summarize();
  end
endmodule : atpb_regs_tb
bind atpb_regs atpb_regs_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .header_unlock(header_unlock),
  .value_unlock(value_unlock), .egress_port(egress_port), .arb_advance(arb_advance),
  .arb_port(arb_port), .arb_port_valid(arb_port_valid),
  .table_coherency_flag(table_coherency_flag));
`default_nettype wire
